// ---- hdl/cid_decoder.sv ----
/*
  Instruction decoder and sequencer: maps an opcode with its operand bytes to
  group, mode, length, time, flag effects, effective address and branch
  outcome, counts out the machine cycles and keeps the condition-code flags.
  Assumes the fetch side presents all operand bytes with the opcode and that
  the datapath strobes flag_upd once per instruction with its ALU flags.
*/
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_decoder
  import cid_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     arst_n,
  input  wire logic     req_valid,
  input  wire cid_req_t req,
  input  wire logic     mem_bit,
  input  wire logic     irq_pin,
  input  wire logic     flag_upd,
  input  wire cid_ccr_t alu_flags,
  input  wire logic     flag_reload,
  input  wire cid_ccr_t stack_flags,
  output logic          busy,
  output logic          done,
  output cid_dec_t      dec,
  output logic [15:0]   eff_addr,
  output logic          branch_taken,
  output logic [15:0]   next_pc,
  output cid_ccr_t      flags
);

  // ========================================================================
  // decode functions
  function automatic cid_dec_t decode(input logic [7:0] op);
    cid_dec_t   d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic       st;
    logic       jump_unconditional;
    logic       jump_to_subroutine;
    hi = op[7:4];
    lo = op[3:0];
    st = (lo == 4'h7) || (lo == 4'hF);
    jump_unconditional = (lo == 4'hC);
    jump_to_subroutine = (lo == 4'hD);
    d = '0;
    // unassigned codes fall through as a one-byte no-operation
    d.group = CID_GRP_INVALID;
    d.mode = CID_MODE_INH;
    d.length = 2'd1;
    d.cycles = `CID_CYC_CTRL;
    case (hi)
      4'h0: begin
        d.group = CID_GRP_BIT;
        d.mode = CID_MODE_BIT_BR;
        d.length = `CID_LEN_BIT_BR;
        d.cycles = `CID_CYC_BIT_BR;
        d.flag_test.c = 1'b1;
        d.reads_mem = 1'b1;
        d.bit_index = op[3:1];
      end
      4'h1: begin
        d.group = CID_GRP_BIT;
        d.mode = CID_MODE_BIT_RW;
        d.length = `CID_LEN_BIT_RW;
        d.cycles = `CID_CYC_BIT_RW;
        d.reads_mem = 1'b1;
        d.write_back = 1'b1;
        d.bit_index = op[3:1];
      end
      4'h2: begin
        d.group = CID_GRP_BRANCH;
        d.mode = CID_MODE_REL;
        d.length = `CID_LEN_REL;
        d.cycles = `CID_CYC_REL;
      end
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        if (!(lo inside {4'h1, 4'h2, 4'h5, 4'hB, 4'hE})) begin
          d.group = CID_GRP_RMW;
          d.use_x = (hi == 4'h5);
          d.reads_mem = (hi == 4'h3) || (hi == 4'h6) || (hi == 4'h7);
          d.write_back = (lo != 4'hD);
          case (hi)
            4'h3: begin
              d.mode = CID_MODE_DIR;
              d.length = 2'd2;
              d.cycles = `CID_CYC_RMW_DIR;
            end
            4'h6: begin
              d.mode = CID_MODE_IXB;
              d.length = 2'd2;
              d.cycles = `CID_CYC_RMW_IXB;
            end
            4'h7: begin
              d.mode = CID_MODE_IX;
              d.cycles = `CID_CYC_RMW_IX;
            end
            default: d.cycles = `CID_CYC_RMW_INH;
          endcase
          case (lo)
            4'h3: begin
              d.flag_test = 5'b00110;
              d.force_one.c = 1'b1;
            end
            4'h4: begin
              d.flag_test = 5'b00011;
              d.force_zero.n = 1'b1;
            end
            4'hF: begin
              d.force_zero.n = 1'b1;
              d.force_one.z = 1'b1;
            end
            4'hA, 4'hC, 4'hD: d.flag_test = 5'b00110;
            default: d.flag_test = 5'b00111;
          endcase
        end
      end
      4'h8: begin
        if (op inside {`CID_OP_RET_INT, `CID_OP_RTS, `CID_OP_SOFT_INT}) begin
          d.group = CID_GRP_CONTROL;
          d.cycles = (op == `CID_OP_RET_INT) ? `CID_CYC_RET_INT :
                     (op == `CID_OP_RTS) ? `CID_CYC_RTS : `CID_CYC_SOFT_INT;
          d.reload = (op == `CID_OP_RET_INT);
          d.force_one.i = (op == `CID_OP_SOFT_INT);
        end
      end
      4'h9: begin
        if (op inside {[`CID_OP_A_TO_X:`CID_OP_NO_OP], `CID_OP_X_TO_A}) begin
          d.group = CID_GRP_CONTROL;
          d.force_zero.c = (op == `CID_OP_CARRY_OFF);
          d.force_one.c = (op == `CID_OP_CARRY_ON);
          d.force_zero.i = (op == `CID_OP_MASK_OFF);
          d.force_one.i = (op == `CID_OP_MASK_ON);
        end
      end
      default: begin
        if (op == `CID_OP_BR_SUB) begin
          d.group = CID_GRP_BRANCH;
          d.mode = CID_MODE_REL;
          d.length = `CID_LEN_REL;
          d.cycles = `CID_CYC_BR_SUB;
        end else if (!((hi == 4'hA) && (st || jump_unconditional || jump_to_subroutine))) begin
          d.group = CID_GRP_REG_MEM;
          d.use_x = (lo == 4'h3) || (lo == 4'hE) || (lo == 4'hF);
          d.reads_mem = !(st || jump_unconditional || jump_to_subroutine) && (hi != 4'hA);
          d.write_back = st;
          case (hi)
            4'hA: begin
              d.mode = CID_MODE_IMM;
              d.length = 2'd2;
              d.cycles = `CID_CYC_RM_IMM;
            end
            4'hB: begin
              d.mode = CID_MODE_DIR;
              d.length = 2'd2;
              d.cycles = `CID_CYC_RM_DIR;
            end
            4'hC: begin
              d.mode = CID_MODE_EXT;
              d.length = 2'd3;
              d.cycles = `CID_CYC_RM_EXT;
            end
            4'hD: begin
              d.mode = CID_MODE_IXW;
              d.length = 2'd3;
              d.cycles = `CID_CYC_RM_IXW;
            end
            4'hE: begin
              d.mode = CID_MODE_IXB;
              d.length = 2'd2;
              d.cycles = `CID_CYC_RM_IXB;
            end
            default: begin
              d.mode = CID_MODE_IX;
              d.cycles = `CID_CYC_RM_IX;
            end
          endcase
          // stores take one more cycle, jumps one less, subroutine jumps three more
          if (st) d.cycles = d.cycles + 4'd1;
          if (jump_unconditional) d.cycles = d.cycles - 4'd1;
          if (jump_to_subroutine) d.cycles = d.cycles + 4'd3;
          if (lo inside {4'h0, 4'h1, 4'h2, 4'h3}) d.flag_test = 5'b00111;
          else if (lo inside {4'h9, 4'hB}) d.flag_test = 5'b10111;
          else if (!(jump_unconditional || jump_to_subroutine)) d.flag_test = 5'b00110;
        end
      end
    endcase
    return d;
  endfunction

  function automatic logic branch_cond(input logic [7:0] op, input cid_ccr_t f, input logic irq);
    logic base;
    case (op[3:1])
      3'd0: base = 1'b1;
      3'd1: base = !(f.c || f.z);
      3'd2: base = !f.c;
      3'd3: base = !f.z;
      3'd4: base = !f.h;
      3'd5: base = !f.n;
      3'd6: base = !f.i;
      default: base = !irq;
    endcase
    return base ^ op[0];
  endfunction

  // ========================================================================
  // interrupt pin synchroniser
  logic irq_s1;
  logic irq_s2;
  logic irq_s3;
  logic irq_level;
  logic next_irq_level;

  always_comb begin
    next_irq_level = (irq_s2 == irq_s3) ? irq_s3 : irq_level;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      irq_s3 <= 1'b0;
      irq_level <= 1'b0;
    end else begin
      irq_s1 <= irq_pin;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      irq_level <= next_irq_level;
    end
  end

  // ========================================================================
  // decode, address and branch
  cid_state_t  state;
  cid_state_t  next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        take;
  cid_dec_t    next_dec;
  logic [15:0] next_eff_addr;
  logic        next_taken;
  logic [15:0] next_next_pc;
  logic        tested_bit;
  logic        next_tested_bit;
  logic        next_done;
  logic [7:0]  rel_off;

  assign take = req_valid && (state == CID_ST_IDLE);

  always_comb begin
    next_dec = dec;
    next_eff_addr = eff_addr;
    next_taken = branch_taken;
    next_next_pc = next_pc;
    next_tested_bit = tested_bit;
    rel_off = (req.opcode[7:4] == 4'h0) ? req.op2 : req.op1;
    if (take) begin
      next_dec = decode(req.opcode);
      next_tested_bit = mem_bit;
      case (next_dec.mode)
        CID_MODE_DIR, CID_MODE_BIT_RW, CID_MODE_BIT_BR: next_eff_addr = {8'h00, req.op1};
        CID_MODE_EXT: next_eff_addr = {req.op1, req.op2};
        CID_MODE_IX: next_eff_addr = {8'h00, req.x};
        CID_MODE_IXB: next_eff_addr = {8'h00, req.x} + {8'h00, req.op1};
        CID_MODE_IXW: next_eff_addr = {req.op1, req.op2} + {8'h00, req.x};
        default: next_eff_addr = 16'h0000;
      endcase
      if (req.opcode[7:4] == 4'h0) next_taken = mem_bit ^ req.opcode[0];
      else if (req.opcode[7:4] == 4'h2) next_taken = branch_cond(req.opcode, flags, irq_level);
      else next_taken = (req.opcode == `CID_OP_BR_SUB);
      next_next_pc = req.pc + {14'h0000, next_dec.length};
      if (next_taken) next_next_pc = next_next_pc + {{8{rel_off[7]}}, rel_off};
    end
  end

  // ========================================================================
  // cycle sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      CID_ST_IDLE: begin
        if (take) begin
          next_state = CID_ST_EXEC;
          next_cnt = next_dec.cycles;
        end
      end
      CID_ST_EXEC: begin
        next_cnt = cnt - 4'd1;
        if (cnt == 4'd1) next_state = CID_ST_IDLE;
      end
      default: begin
        next_state = CID_ST_IDLE;
        next_cnt = 4'd0;
      end
    endcase
    next_done = (next_state == CID_ST_EXEC) && (next_cnt == 4'd1);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CID_ST_IDLE;
      cnt <= 4'd0;
      busy <= 1'b0;
      done <= 1'b0;
      dec <= '0;
      eff_addr <= 16'h0000;
      branch_taken <= 1'b0;
      next_pc <= 16'h0000;
      tested_bit <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      busy <= (next_state == CID_ST_EXEC);
      done <= next_done;
      dec <= next_dec;
      eff_addr <= next_eff_addr;
      branch_taken <= next_taken;
      next_pc <= next_next_pc;
      tested_bit <= next_tested_bit;
    end
  end

  // ========================================================================
  // condition-code flags
  cid_ccr_t next_flags;
  cid_ccr_t upd_val;

  always_comb begin
    upd_val = alu_flags;
    if (dec.mode == CID_MODE_BIT_BR) upd_val.c = tested_bit;
    next_flags = flags;
    if (flag_reload) next_flags = stack_flags;
    else if (flag_upd) next_flags = (flags & ~dec.flag_test & ~dec.force_zero) | (upd_val & dec.flag_test) | dec.force_one;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) flags <= `CID_CCR_RESET;
    else flags <= next_flags;
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence noop_run_s;
    busy ##1 (busy && done) ##1 !busy;
  endsequence

  adc_imm_a: assert property (take && req.opcode == 8'hA9 |=> dec.length == 2'd2 && dec.cycles == 4'd2 && dec.flag_test.h)
    else $error("add with carry immediate decoded wrong");
  cmp_index_a: assert property (take && req.opcode == 8'hD3 |=> dec.flag_test == 5'b00111 && !dec.write_back && dec.use_x)
    else $error("compare index decoded wrong");
  jump_time_a: assert property (take && req.opcode == 8'hBC |=> dec.cycles == 4'd3)
    else $error("jump cycles wrong");
  sub_jump_time_a: assert property (take && req.opcode == 8'hDD |=> dec.cycles == 4'd9 && dec.length == 2'd3)
    else $error("subroutine jump timing wrong");
  test_no_write_a: assert property (take && req.opcode == 8'h6D |=> !dec.write_back && dec.cycles == 4'd7)
    else $error("test operation writes back");
  irq_branch_a: assert property (take && req.opcode == 8'h2F |=> branch_taken == $past(irq_level))
    else $error("pin branch wrong");
  bit_branch_a: assert property (take && req.opcode[7:4] == 4'h0 |=> branch_taken == ($past(mem_bit) ^ $past(req.opcode[0])))
    else $error("bit test branch wrong");
  bit_set_a: assert property (take && req.opcode[7:4] == 4'h1 |=> dec.length == 2'd2 && dec.cycles == 4'd7)
    else $error("bit set clear timing wrong");
  noop_seq_a: assert property (take && req.opcode == `CID_OP_NO_OP |=> noop_run_s)
    else $error("two cycle sequence wrong");
  reload_a: assert property (flag_reload |=> flags == $past(stack_flags))
    else $error("flag reload failed");
  half_hold_a: assert property (!flag_reload && !(flag_upd && dec.flag_test.h) |=> flags.h == $past(flags.h))
    else $error("half carry changed");
  unused_op_a: assert property (take && req.opcode == 8'h8E |=> dec.group == CID_GRP_INVALID && dec.length == 2'd1)
    else $error("unassigned opcode not a no-operation");

endmodule

// ---- hdl/cid_params.svh ----
/*
  Constants for the instruction decoder: opcode values, per-mode byte lengths,
  machine-cycle counts and the flag reset value.
  Assumes it is included by bare name after the cid_pkg types are visible.
*/
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// ==========================================================================
// fixed opcodes
`define CID_OP_RET_INT   8'h80
`define CID_OP_RTS       8'h81
`define CID_OP_SOFT_INT  8'h83
`define CID_OP_A_TO_X    8'h97
`define CID_OP_CARRY_OFF 8'h98
`define CID_OP_CARRY_ON  8'h99
`define CID_OP_MASK_OFF  8'h9A
`define CID_OP_MASK_ON   8'h9B
`define CID_OP_SP_INIT   8'h9C
`define CID_OP_NO_OP     8'h9D
`define CID_OP_X_TO_A    8'h9F
`define CID_OP_BR_SUB    8'hAD

// ==========================================================================
// lengths in bytes and times in machine cycles
`define CID_LEN_BIT_BR   2'd3
`define CID_CYC_BIT_BR   4'd10
`define CID_LEN_BIT_RW   2'd2
`define CID_CYC_BIT_RW   4'd7
`define CID_LEN_REL      2'd2
`define CID_CYC_REL      4'd4
`define CID_CYC_BR_SUB   4'd8
`define CID_CYC_RET_INT  4'd9
`define CID_CYC_RTS      4'd6
`define CID_CYC_SOFT_INT 4'd11
`define CID_CYC_CTRL     4'd2
`define CID_CYC_RMW_DIR  4'd6
`define CID_CYC_RMW_INH  4'd4
`define CID_CYC_RMW_IXB  4'd7
`define CID_CYC_RMW_IX   4'd6
`define CID_CYC_RM_IMM   4'd2
`define CID_CYC_RM_DIR   4'd4
`define CID_CYC_RM_EXT   4'd5
`define CID_CYC_RM_IXW   4'd6
`define CID_CYC_RM_IXB   4'd5
`define CID_CYC_RM_IX    4'd4

// flags after reset, order h i n z c: mask set, rest clear
`define CID_CCR_RESET   5'b01000

`endif

// ---- hdl/cid_pkg.sv ----
/*
  Types shared by the instruction decoder: groups, addressing modes, flag set,
  request and decode result records.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cid_pkg;

  typedef enum logic [5:0] {
    CID_GRP_REG_MEM = 6'b000001,
    CID_GRP_RMW     = 6'b000010,
    CID_GRP_BRANCH  = 6'b000100,
    CID_GRP_BIT     = 6'b001000,
    CID_GRP_CONTROL = 6'b010000,
    CID_GRP_INVALID = 6'b100000
  } cid_group_t;

  typedef enum logic [9:0] {
    CID_MODE_INH = 10'b00_0000_0001,
    CID_MODE_IMM = 10'b00_0000_0010,
    CID_MODE_DIR = 10'b00_0000_0100,
    CID_MODE_EXT = 10'b00_0000_1000,
    CID_MODE_REL = 10'b00_0001_0000,
    CID_MODE_IX  = 10'b00_0010_0000,
    CID_MODE_IXB    = 10'b00_0100_0000,
    CID_MODE_IXW    = 10'b00_1000_0000,
    CID_MODE_BIT_RW = 10'b01_0000_0000,
    CID_MODE_BIT_BR = 10'b10_0000_0000
  } cid_mode_t;

  typedef enum logic [1:0] {
    CID_ST_IDLE = 2'b01,
    CID_ST_EXEC = 2'b10
  } cid_state_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cid_ccr_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] pc;
    logic [7:0]  x;
  } cid_req_t;

  typedef struct packed {
    cid_group_t group;
    cid_mode_t  mode;
    logic [1:0] length;
    logic [3:0] cycles;
    cid_ccr_t   flag_test;
    cid_ccr_t   force_one;
    cid_ccr_t   force_zero;
    logic       reload;
    logic       reads_mem;
    logic       write_back;
    logic       use_x;
    logic [2:0] bit_index;
  } cid_dec_t;

endpackage

// ---- tb/cid_mem_model.sv ----
/*
  Program memory model: shows the opcode and the two bytes after it at pc,
  with the index register, as one request record.
  Assumes the bench loads mem before it raises req_valid.
*/
`timescale 1ns/1ps
// ==========================================================================
// memory
module cid_mem_model
  import cid_pkg::*;
(
  input  wire logic [15:0] pc,
  input  wire logic [7:0]  x,
  output cid_req_t         req
);
  logic [7:0] mem [0:255];

  // only the low byte of pc selects, so operand bytes wrap inside one page
  always_comb begin
    req.opcode = mem[pc[7:0]];
    req.op1    = mem[pc[7:0] + 8'h01];
    req.op2    = mem[pc[7:0] + 8'h02];
    req.pc     = pc;
    req.x      = x;
  end
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the instruction decoder: lengths and times, address
  forming, branch conditions, flag effects, bit operations, refusal, reset.
  Assumes cid_pkg, cid_decoder and cid_mem_model are compiled first.
*/
`timescale 1ns/1ps
module tb
  import cid_pkg::*;
;
  // ==========================================================================
  // signals
  logic        clk         = 1'b0;
  logic        arst_n      = 1'b0;
  logic        req_valid   = 1'b0;
  logic [15:0] pc          = 16'h0100;
  logic [7:0]  x           = 8'h00;
  logic        mem_bit     = 1'b0;
  logic        irq_pin     = 1'b0;
  logic        flag_upd    = 1'b0;
  logic        flag_reload = 1'b0;
  cid_ccr_t    alu_flags   = 5'h00;
  cid_ccr_t    stack_flags = 5'h00;
  cid_req_t    req;
  logic        busy;
  logic        done;
  cid_dec_t    dec;
  logic [15:0] eff_addr;
  logic        branch_taken;
  logic [15:0] next_pc;
  cid_ccr_t    flags;
  int          bad_count   = 0;
  int          comparisons = 0;
  int          n_busy;
  int          n_done;

  always #12.5 clk = ~clk;

  cid_mem_model u_mem (.pc(pc), .x(x), .req(req));

  cid_decoder u_dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .mem_bit(mem_bit),
    .irq_pin(irq_pin), .flag_upd(flag_upd), .alu_flags(alu_flags), .flag_reload(flag_reload),
    .stack_flags(stack_flags), .busy(busy), .done(done), .dec(dec), .eff_addr(eff_addr),
    .branch_taken(branch_taken), .next_pc(next_pc), .flags(flags));

  // ==========================================================================
  // shared tasks
  task automatic final_report();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    u_mem.mem[pc[7:0]] = op;
    u_mem.mem[pc[7:0] + 8'h01] = b1;
    u_mem.mem[pc[7:0] + 8'h02] = b2;
  endtask

  // counts busy cycles and notes the cycle in which done showed
  task automatic wait_idle();
    n_busy = 0;
    n_done = -1;
    while (busy === 1'b1 && n_busy < 20) begin
      if (done === 1'b1) n_done = n_busy;
      @(posedge clk);
      #2;
      n_busy++;
    end
    if (busy !== 1'b0) begin
      bad_count++;
      final_report();
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk);
    #2;
    load(op, b1, b2);
    req_valid = 1'b1;
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    wait_idle();
  endtask

  task automatic strobe(input logic u, input logic r, input cid_ccr_t a, input cid_ccr_t s);
    @(posedge clk);
    #2;
    flag_upd = u;
    flag_reload = r;
    alu_flags = a;
    stack_flags = s;
    @(posedge clk);
    #2;
    flag_upd = 1'b0;
    flag_reload = 1'b0;
  endtask

  task automatic chk_reset();
    chk(48'(busy), 48'h0);
    chk(48'(done), 48'h0);
    chk(48'(dec), 48'h0);
    chk(48'(eff_addr), 48'h0);
    chk(48'(branch_taken), 48'h0);
    chk(48'(next_pc), 48'h0);
    chk(48'(flags), 48'h08);
  endtask

  // ==========================================================================
  // scenarios
  // entry: opcode, length, cycles, group bit
  task automatic t_timing();
    logic [19:0] tbl [24];
    tbl = '{20'hA_9220, 20'hB_9240, 20'hC_9350, 20'hD_9360, 20'hE_9250, 20'hF_9140, 20'hB_C230, 20'hD_D390,
            20'h4_C141, 20'h3_C261, 20'h6_C271, 20'h7_C161, 20'h2_0242, 20'hA_D282, 20'h0_03A3, 20'h1_0273,
            20'h9_7124, 20'h9_D124, 20'h8_0194, 20'h8_1164, 20'h8_31B4, 20'h8_E125, 20'h6_D271, 20'hD_3360};
    foreach (tbl[k]) begin
      run(tbl[k][19:12], 8'h00, 8'h00);
      chk(48'(dec.length), 48'(tbl[k][11:8]));
      chk(48'(n_busy), 48'(tbl[k][7:4]));
      chk(48'(n_done), 48'(tbl[k][7:4]) - 48'h1);
      chk(48'(dec.group), 48'h1 << tbl[k][3:0]);
      chk(48'(next_pc), 48'(pc + 16'(tbl[k][11:8])));
    end
  endtask

  task automatic t_addr();
    x = 8'hF0;
    run(8'hE9, 8'h20, 8'h00);
    chk(48'(eff_addr), 48'h0110);
    run(8'hD9, 8'h12, 8'h34);
    chk(48'(eff_addr), 48'h1324);
    run(8'hB9, 8'h45, 8'h00);
    chk(48'(eff_addr), 48'h0045);
    run(8'hC9, 8'h12, 8'h34);
    chk(48'(eff_addr), 48'h1234);
    run(8'hF9, 8'h00, 8'h00);
    chk(48'(eff_addr), 48'h00F0);
    run(8'hAE, 8'h00, 8'h00);
    chk(48'(dec.use_x), 48'h1);
  endtask

  // relies on the mask still being set from reset
  task automatic t_branch();
    run(8'h20, 8'hFE, 8'h00);
    chk(48'(branch_taken), 48'h1);
    chk(48'(next_pc), 48'h0100);
    run(8'h21, 8'h05, 8'h00);
    chk(48'(next_pc), 48'h0102);
    run(8'h2D, 8'h10, 8'h00);
    chk(48'(next_pc), 48'h0112);
    run(8'h2C, 8'h10, 8'h00);
    chk(48'(branch_taken), 48'h0);
    for (int k = 0; k < 2; k++) begin
      irq_pin = k[0];
      // the pin passes a synchroniser first
      repeat (6) @(posedge clk);
      run(8'h2E, 8'h00, 8'h00);
      chk({47'h0, branch_taken}, {47'h0, ~k[0]});
      run(8'h2F, 8'h00, 8'h00);
      chk({47'h0, branch_taken}, {47'h0, k[0]});
    end
  endtask

  task automatic t_flags();
    run(8'hAB, 8'h00, 8'h00);
    strobe(1'b1, 1'b0, 5'h10, 5'h00);
    chk(48'(flags), 48'h18);
    run(8'h29, 8'h04, 8'h00);
    chk(48'(branch_taken), 48'h1);
    run(8'h28, 8'h04, 8'h00);
    chk(48'(branch_taken), 48'h0);
    run(8'hB6, 8'h00, 8'h00);
    chk(48'(dec.use_x), 48'h0);
    strobe(1'b1, 1'b0, 5'h04, 5'h00);
    chk(48'(flags), 48'h1C);
    run(8'h4F, 8'h00, 8'h00);
    strobe(1'b1, 1'b0, 5'h04, 5'h00);
    chk(48'(flags), 48'h1A);
    run(8'h43, 8'h00, 8'h00);
    strobe(1'b1, 1'b0, 5'h00, 5'h00);
    chk(48'(flags), 48'h19);
    run(8'h9A, 8'h00, 8'h00);
    strobe(1'b1, 1'b0, 5'h1F, 5'h00);
    chk(48'(flags), 48'h11);
    run(8'h2C, 8'h04, 8'h00);
    chk(48'(branch_taken), 48'h1);
    run(8'h83, 8'h00, 8'h00);
    strobe(1'b1, 1'b0, 5'h00, 5'h00);
    chk(48'(flags), 48'h19);
    run(8'hA3, 8'h00, 8'h00);
    chk(48'(dec.flag_test), 48'h07);
    chk(48'(dec.use_x), 48'h1);
    strobe(1'b1, 1'b0, 5'h00, 5'h00);
    chk(48'(flags), 48'h18);
    run(8'h80, 8'h00, 8'h00);
    chk(48'(dec.reload), 48'h1);
    // reload must win over a simultaneous update
    strobe(1'b1, 1'b1, 5'h1F, 5'h05);
    chk(48'(flags), 48'h05);
    run(8'h4D, 8'h00, 8'h00);
    chk(48'(dec.write_back), 48'h0);
    chk(48'(dec.flag_test), 48'h06);
    run(8'h3D, 8'h20, 8'h00);
    chk(48'(dec.write_back), 48'h0);
    chk(48'(dec.reads_mem), 48'h1);
    run(8'h6C, 8'h20, 8'h00);
    chk(48'(dec.write_back), 48'h1);
    run(8'h9D, 8'h00, 8'h00);
    strobe(1'b1, 1'b0, 5'h1F, 5'h00);
    chk(48'(flags), 48'h05);
  endtask

  task automatic t_bits();
    pc = 16'h0200;
    mem_bit = 1'b1;
    run(8'h0E, 8'h10, 8'h7F);
    chk(48'(dec.bit_index), 48'h7);
    chk(48'(eff_addr), 48'h0010);
    chk(48'(next_pc), 48'h0282);
    run(8'h0F, 8'h10, 8'h7F);
    chk(48'(next_pc), 48'h0203);
    mem_bit = 1'b0;
    run(8'h01, 8'h10, 8'h80);
    chk(48'(next_pc), 48'h0183);
    strobe(1'b1, 1'b0, 5'h01, 5'h00);
    chk(48'(flags), 48'h04);
    run(8'h1F, 8'h40, 8'h00);
    chk(48'(dec.bit_index), 48'h7);
    chk(48'(eff_addr), 48'h0040);
  endtask

  // a second request while busy must be ignored; then reset mid-instruction
  task automatic t_refuse();
    pc = 16'h0300;
    @(posedge clk);
    #2;
    load(8'h83, 8'h00, 8'h00);
    req_valid = 1'b1;
    @(posedge clk);
    #2;
    load(8'h9D, 8'h00, 8'h00);
    repeat (5) @(posedge clk);
    #2;
    req_valid = 1'b0;
    chk(48'(dec.cycles), 48'hB);
    wait_idle();
    chk(48'(n_busy), 48'h6);
    run(8'h83, 8'h00, 8'h00);
    @(posedge clk);
    #2;
    load(8'h83, 8'h00, 8'h00);
    req_valid = 1'b1;
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    arst_n = 1'b0;
    #1;
    chk_reset();
    @(posedge clk);
    #2;
    arst_n = 1'b1;
    chk(48'(busy), 48'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2;
    chk_reset();
    @(posedge clk);
    #2;
    arst_n = 1'b1;
    t_timing();
    t_addr();
    t_branch();
    t_flags();
    t_bits();
    t_refuse();
    final_report();
  end
endmodule
